//--- src/lrc_pkg.sv
// lrc_pkg: command codes, field layout, reset values and timing for the lock/config bank
package lrc_pkg;

  // command codes seen on the management port
  localparam logic [7:0] LRC_CMD_LOCK_RST = 8'hd0;
  localparam logic [7:0] LRC_CMD_SUP_CFG  = 8'hd1;

  // lock_and_soft_reset field positions
  localparam int unsigned LRC_BIT_LOCK    = 0;
  localparam int unsigned LRC_BIT_SOFTRST = 1;

  // supervisor_configuration field positions
  localparam int unsigned LRC_BIT_MON_EN   = 0;
  localparam int unsigned LRC_BIT_ALERT_EN = 1;
  localparam int unsigned LRC_BIT_FAULT_EN = 2;
  localparam int unsigned LRC_BIT_BUSTO_EN = 3;
  localparam int unsigned LRC_POS_PHASE_LO = 6;
  localparam int unsigned LRC_POS_PHASE_HI = 7;

  // power-on values
  localparam logic [7:0] LRC_RST_LOCK_RST = 8'h00;
  localparam logic [7:0] LRC_RST_SUP_CFG  = 8'h07;

  // light-load phase-count codes and resulting phase counts
  localparam logic [1:0] LRC_PHASE_CODE_TWO = 2'h1;
  localparam logic [1:0] LRC_PHASES_ONE     = 2'h1;
  localparam logic [1:0] LRC_PHASES_TWO     = 2'h2;

  // bus idle timeout
  localparam int unsigned LRC_CLK_HZ        = 125_000_000;
  localparam int unsigned LRC_BUS_TO_MS     = 35;
  localparam int unsigned LRC_BUS_TO_CYCLES = LRC_BUS_TO_MS * (LRC_CLK_HZ / 1000);
  localparam int unsigned LRC_TO_CNT_W      = 23;

  // supervisor_configuration as a packed carrier
  typedef struct packed {
    logic [1:0] light_load_phase_count;
    logic [1:0] rsvd;
    logic       bus_idle_timeout_enable;
    logic       fault_pin_enable;
    logic       alert_pin_enable;
    logic       monitor_enable;
  } lrc_cfg_t;

  // monitor sequencer
  typedef enum logic [1:0] {
    LRC_MON_IDLE = 2'b00,
    LRC_MON_WAIT = 2'b01
  } lrc_mon_state_t;

endpackage

//--- src/lrc_bus_timeout.sv
// lrc_bus_timeout: idle watchdog on a transaction addressed to the device
`timescale 1ns/1ps
module lrc_bus_timeout
  import lrc_pkg::*;
#(
  parameter logic [LRC_TO_CNT_W-1:0] LIMIT = LRC_TO_CNT_W'(LRC_BUS_TO_CYCLES)
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic enable_i,
  input  wire logic xact_active_i,
  input  wire logic bus_activity_i,
  // result
  output logic      release_o
);

  logic [LRC_TO_CNT_W-1:0] cnt_q;
  logic [LRC_TO_CNT_W-1:0] cnt_d;
  logic                    release_q;
  logic                    release_d;
  logic                    fired_q;
  logic                    fired_d;

  always_comb begin
    cnt_d     = cnt_q;
    release_d = 1'b0;
    fired_d   = fired_q;
    if (!enable_i || !xact_active_i || bus_activity_i) begin
      cnt_d   = '0;
      fired_d = 1'b0;
    end else if (cnt_q < LIMIT) begin
      cnt_d = cnt_q + LRC_TO_CNT_W'(1);
    end else if (!fired_q) begin
      // idle has now exceeded the limit; one release per stall
      release_d = 1'b1;
      fired_d   = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_q     <= '0;
      release_q <= 1'b0;
      fired_q   <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      release_q <= release_d;
      fired_q   <= fired_d;
    end
  end

  assign release_o = release_q;

endmodule

//--- src/lrc_regs.sv
// lrc_regs: lock/soft-reset and supervisor configuration command registers
`timescale 1ns/1ps
module lrc_regs
  import lrc_pkg::*;
#(
  parameter logic [LRC_TO_CNT_W-1:0] BUS_TO_CYCLES = LRC_TO_CNT_W'(LRC_BUS_TO_CYCLES)
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // command port from the serial protocol engine
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] cmd_code_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  // bus activity for the idle watchdog
  input  wire logic       xact_active_i,
  input  wire logic       bus_activity_i,
  output logic            bus_release_o,
  // lock and restore to the rest of the register file
  output logic            lock_o,
  output logic            soft_reset_o,
  // power-save phase count
  output logic      [1:0] active_phases_o,
  // fault pin, open drain, active low
  input  wire logic       fault_req_i,
  output logic            fault_n_o,
  output logic            fault_oe_o,
  // alert pin, open drain, active low
  input  wire logic       alert_req_i,
  output logic            alert_n_o,
  output logic            alert_oe_o,
  // converter handshake
  input  wire logic       adc_done_i,
  output logic            adc_start_o,
  output logic            monitor_on_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] phases_for(input logic [1:0] code);
    phases_for = (code == LRC_PHASE_CODE_TWO) ? LRC_PHASES_TWO : LRC_PHASES_ONE;
  endfunction

  function automatic lrc_cfg_t cfg_reset();
    cfg_reset = lrc_cfg_t'(LRC_RST_SUP_CFG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic     lock_q;
  logic     lock_d;
  logic     rst_pend_q;
  logic     rst_pend_d;
  lrc_cfg_t cfg_q;
  lrc_cfg_t cfg_d;
  logic     soft_reset_q;
  logic     soft_reset_d;
  logic     wr_lock;
  logic     wr_cfg;

  assign wr_lock = wr_en_i && (cmd_code_i == LRC_CMD_LOCK_RST);
  assign wr_cfg  = wr_en_i && (cmd_code_i == LRC_CMD_SUP_CFG);

  always_comb begin
    lock_d       = lock_q;
    rst_pend_d   = 1'b0;
    cfg_d        = cfg_q;
    soft_reset_d = 1'b0;
    if (rst_pend_q) begin
      // restore runs the cycle after the request; a write in that cycle loses
      cfg_d  = cfg_reset();
      lock_d = LRC_RST_LOCK_RST[LRC_BIT_LOCK];
    end else begin
      if (wr_lock && !lock_q) begin
        // once set, no write can clear lock; only power-on reset does
        lock_d = wr_data_i[LRC_BIT_LOCK];
        if (wr_data_i[LRC_BIT_SOFTRST] && !wr_data_i[LRC_BIT_LOCK]) begin
          rst_pend_d   = 1'b1;
          soft_reset_d = 1'b1;
        end
      end
      if (wr_cfg) begin
        cfg_d.light_load_phase_count = wr_data_i[LRC_POS_PHASE_HI:LRC_POS_PHASE_LO];
        cfg_d.fault_pin_enable       = wr_data_i[LRC_BIT_FAULT_EN];
        cfg_d.alert_pin_enable       = wr_data_i[LRC_BIT_ALERT_EN];
        cfg_d.monitor_enable         = wr_data_i[LRC_BIT_MON_EN];
        if (!lock_q) begin
          cfg_d.bus_idle_timeout_enable = wr_data_i[LRC_BIT_BUSTO_EN];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lock_q       <= LRC_RST_LOCK_RST[LRC_BIT_LOCK];
      rst_pend_q   <= LRC_RST_LOCK_RST[LRC_BIT_SOFTRST];
      cfg_q        <= lrc_cfg_t'(LRC_RST_SUP_CFG);
      soft_reset_q <= 1'b0;
    end else begin
      lock_q       <= lock_d;
      rst_pend_q   <= rst_pend_d;
      cfg_q        <= cfg_d;
      soft_reset_q <= soft_reset_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back

  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       rd_valid_q;
  logic       rd_valid_d;

  always_comb begin
    rd_data_d  = rd_data_q;
    rd_valid_d = rd_en_i;
    if (rd_en_i) begin
      unique case (cmd_code_i)
        LRC_CMD_LOCK_RST: begin
          rd_data_d = 8'h00;
          rd_data_d[LRC_BIT_LOCK]    = lock_q;
          rd_data_d[LRC_BIT_SOFTRST] = rst_pend_q;
        end
        LRC_CMD_SUP_CFG: begin
          rd_data_d = cfg_q;
          rd_data_d[LRC_POS_PHASE_LO-1:LRC_BIT_BUSTO_EN+1] = 2'h0;
        end
        default: begin
          // other codes belong to other banks
          rd_data_d  = 8'h00;
          rd_valid_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and phase count

  logic       fault_oe_q;
  logic       fault_oe_d;
  logic       alert_oe_q;
  logic       alert_oe_d;
  logic [1:0] phases_q;
  logic [1:0] phases_d;

  always_comb begin
    fault_oe_d = cfg_q.fault_pin_enable && fault_req_i;
    alert_oe_d = cfg_q.alert_pin_enable && alert_req_i;
    phases_d   = phases_for(cfg_q.light_load_phase_count);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fault_oe_q <= 1'b0;
      alert_oe_q <= 1'b0;
      phases_q   <= LRC_PHASES_ONE;
    end else begin
      fault_oe_q <= fault_oe_d;
      alert_oe_q <= alert_oe_d;
      phases_q   <= phases_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor sequencer: one conversion in flight at a time

  lrc_mon_state_t mon_q;
  lrc_mon_state_t mon_d;
  logic           start_q;
  logic           start_d;
  logic           mon_on_q;
  logic           mon_on_d;

  always_comb begin
    mon_d    = mon_q;
    start_d  = 1'b0;
    mon_on_d = cfg_q.monitor_enable;
    unique case (mon_q)
      LRC_MON_IDLE: begin
        if (cfg_q.monitor_enable) begin
          start_d = 1'b1;
          mon_d   = LRC_MON_WAIT;
        end
      end
      LRC_MON_WAIT: begin
        // a conversion already started is allowed to finish
        if (adc_done_i) begin
          mon_d = LRC_MON_IDLE;
        end
      end
      default: begin
        mon_d = LRC_MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mon_q    <= LRC_MON_IDLE;
      start_q  <= 1'b0;
      mon_on_q <= 1'b0;
    end else begin
      mon_q    <= mon_d;
      start_q  <= start_d;
      mon_on_q <= mon_on_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus idle watchdog

  lrc_bus_timeout #(
    .LIMIT (BUS_TO_CYCLES)
  ) u_bus_timeout (
    .mclk_i         (mclk_i),
    .rst_n_i        (rst_n_i),
    .enable_i       (cfg_q.bus_idle_timeout_enable),
    .xact_active_i  (xact_active_i),
    .bus_activity_i (bus_activity_i),
    .release_o      (bus_release_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_data_o       = rd_data_q;
  assign rd_valid_o      = rd_valid_q;
  assign lock_o          = lock_q;
  assign soft_reset_o    = soft_reset_q;
  assign active_phases_o = phases_q;
  assign fault_n_o       = 1'b0;
  assign fault_oe_o      = fault_oe_q;
  assign alert_n_o       = 1'b0;
  assign alert_oe_o      = alert_oe_q;
  assign adc_start_o     = start_q;
  assign monitor_on_o    = mon_on_q;

endmodule

//--- test/lrc_regs_assertions.sv
// lrc_regs_assertions: port-level properties of the lock/config bank
`timescale 1ns/1ps
module lrc_regs_checker
  import lrc_pkg::*;
#(
  parameter logic [LRC_TO_CNT_W-1:0] BUS_TO_CYCLES = LRC_TO_CNT_W'(LRC_BUS_TO_CYCLES)
) (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // watched ports
  input wire logic       wr_en_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       xact_active_i,
  input wire logic       bus_activity_i,
  input wire logic       bus_release_o,
  input wire logic       lock_o,
  input wire logic       soft_reset_o,
  input wire logic [1:0] active_phases_o,
  input wire logic       fault_req_i,
  input wire logic       fault_oe_o,
  input wire logic       alert_req_i,
  input wire logic       alert_oe_o,
  input wire logic       adc_start_o,
  input wire logic       monitor_on_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire         wr_lr = wr_en_i && cmd_code_i == LRC_CMD_LOCK_RST;
  wire         wr_cf = wr_en_i && cmd_code_i == LRC_CMD_SUP_CFG;
  logic [31:0] idle_q;
  logic [31:0] idle_d;
  ////////////////////////////////////////////////////////////////
  // length of the current stall, independent of the enable bit
  always_comb begin
    idle_d = (xact_active_i && !bus_activity_i) ? idle_q + 32'd1 : 32'd0;
  end
  always_ff @(posedge mclk_i) begin
    idle_q <= rst_n_i ? idle_d : 32'd0;
  end
  ////////////////////////////////////////////////////////////////
  // pin enables as the host last left them; a write beside a restore loses
  logic        fen_q;
  logic        fen_d;
  logic        aen_q;
  logic        aen_d;
  always_comb begin
    fen_d = fen_q;
    aen_d = aen_q;
    if (soft_reset_o) begin
      fen_d = LRC_RST_SUP_CFG[LRC_BIT_FAULT_EN];
      aen_d = LRC_RST_SUP_CFG[LRC_BIT_ALERT_EN];
    end else if (wr_cf) begin
      fen_d = wr_data_i[LRC_BIT_FAULT_EN];
      aen_d = wr_data_i[LRC_BIT_ALERT_EN];
    end
  end
  always_ff @(posedge mclk_i) begin
    fen_q <= rst_n_i ? fen_d : LRC_RST_SUP_CFG[LRC_BIT_FAULT_EN];
    aen_q <= rst_n_i ? aen_d : LRC_RST_SUP_CFG[LRC_BIT_ALERT_EN];
  end
  ////////////////////////////////////////////////////////////////
  chk_soft_reset_pulse: assert property (wr_lr && wr_data_i[1] && !wr_data_i[0] && !lock_o && !soft_reset_o
    |=> soft_reset_o ##1 !soft_reset_o) else $error("soft reset pulse missing");
  chk_reset_when_locked: assert property (wr_lr && lock_o |=> !soft_reset_o)
    else $error("soft reset while locked");
  chk_lock_set: assert property (wr_lr && wr_data_i[0] && !soft_reset_o |=> lock_o)
    else $error("lock not set");
  chk_lock_sticky: assert property (lock_o |=> lock_o) else $error("lock cleared");
  chk_phase_map: assert property (wr_cf && !soft_reset_o |=> ##1 active_phases_o ==
    (($past(wr_data_i, 2) >> 6) == 8'h01 ? LRC_PHASES_TWO : LRC_PHASES_ONE)) else $error("phase count wrong");
  chk_release_stall: assert property (bus_release_o |-> idle_q >= 32'(BUS_TO_CYCLES) + 32'd1)
    else $error("bus released too early");
  chk_fault_gate: assert property (fault_oe_o |-> $past(fault_req_i) && $past(fen_q))
    else $error("fault pin driven");
  chk_alert_gate: assert property (alert_oe_o |-> $past(alert_req_i) && $past(aen_q))
    else $error("alert pin driven");
  chk_monitor_quiet: assert property (!monitor_on_o [*3] |-> !adc_start_o)
    else $error("conversion started while off");
endmodule

bind lrc_regs lrc_regs_checker #(.BUS_TO_CYCLES(BUS_TO_CYCLES)) i_chk (.mclk_i, .rst_n_i, .wr_en_i, .cmd_code_i,
  .wr_data_i, .xact_active_i, .bus_activity_i, .bus_release_o, .lock_o, .soft_reset_o, .active_phases_o,
  .fault_req_i, .fault_oe_o, .alert_req_i, .alert_oe_o, .adc_start_o, .monitor_on_o);

//--- test/lrc_host_model.sv
// lrc_host_model: command-port master standing in for the serial engine
`timescale 1ns/1ps
module lrc_host_model (
  // clock
  input  wire logic       mclk_i,
  // command port
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] cmd_o,
  output logic      [7:0] data_o,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i
);
  initial begin
    {wr_en_o, rd_en_o, cmd_o, data_o} = 18'h0_0000;
  end
  // idle lines inverted so a stale byte never looks fresh
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge mclk_i);
    {wr_en_o, cmd_o, data_o} = {1'b1, c, d};
    @(negedge mclk_i);
    {wr_en_o, cmd_o, data_o} = {1'b0, ~c, ~d};
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic ok);
    @(negedge mclk_i);
    {rd_en_o, cmd_o} = {1'b1, c};
    @(negedge mclk_i);
    ok = rd_valid_i;
    d  = rd_data_i;
    {rd_en_o, cmd_o} = {1'b0, ~c};
  endtask
endmodule

//--- test/lrc_regs_tb.sv
// lrc_regs_tb: directed scenarios for the lock/config bank
`timescale 1ns/1ps
module lrc_regs_tb;
  import lrc_pkg::*;
  localparam logic [7:0] LR = LRC_CMD_LOCK_RST;
  localparam logic [7:0] CF = LRC_CMD_SUP_CFG;
  logic       mclk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       xact = 1'b0, act = 1'b0, freq = 1'b0, areq = 1'b0;
  logic       wr_en, rd_en, rvld, rel, lock, srst, fn, foe, an, aoe, start, mon;
  logic [7:0] cmd, wdat, rdat;
  logic [1:0] phases;
  logic [2:0] sh = 3'h0;
  int         bad_count = 0, comparisons = 0, n_start = 0;
  always #4 mclk_i = ~mclk_i;
  // converter answers three cycles after each start
  always @(negedge mclk_i) begin
    sh <= {sh[1:0], start};
    if (start === 1'b1) n_start++;
  end
  lrc_host_model i_host (.mclk_i, .wr_en_o(wr_en), .rd_en_o(rd_en), .cmd_o(cmd), .data_o(wdat),
    .rd_data_i(rdat), .rd_valid_i(rvld));
  lrc_regs #(.BUS_TO_CYCLES(23'd20)) i_dut (.mclk_i, .rst_n_i, .wr_en_i(wr_en), .rd_en_i(rd_en),
    .cmd_code_i(cmd), .wr_data_i(wdat), .rd_data_o(rdat), .rd_valid_o(rvld), .xact_active_i(xact),
    .bus_activity_i(act), .bus_release_o(rel), .lock_o(lock), .soft_reset_o(srst), .active_phases_o(phases),
    .fault_req_i(freq), .fault_n_o(fn), .fault_oe_o(foe), .alert_req_i(areq), .alert_n_o(an),
    .alert_oe_o(aoe), .adc_done_i(sh[2]), .adc_start_o(start), .monitor_on_o(mon));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    i_host.rd(c, d, ok);
    chk({nm, " valid"}, 8'h01, {7'h00, ok});
    chk(nm, e, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_por;
    rdchk("lock_rst", LR, LRC_RST_LOCK_RST);
    rdchk("config", CF, LRC_RST_SUP_CFG);
  endtask
  task automatic t_phase;
    for (int c = 0; c < 4; c++) begin
      i_host.wr(CF, {c[1:0], 6'h07});
      cyc(2);
      chk("phases", (c == 1) ? 8'h02 : 8'h01, {6'h00, phases});
    end
  endtask
  task automatic t_pins;
    {freq, areq} = 2'b11;
    i_host.wr(CF, 8'h07);
    cyc(2);
    chk("fault_oe on", 8'h01, {7'h00, foe});
    chk("alert_oe on", 8'h01, {7'h00, aoe});
    chk("fault level", 8'h00, {7'h00, fn});
    chk("alert level", 8'h00, {7'h00, an});
    i_host.wr(CF, 8'h01);
    cyc(2);
    chk("fault_oe off", 8'h00, {7'h00, foe});
    chk("alert_oe off", 8'h00, {7'h00, aoe});
    {freq, areq} = 2'b00;
  endtask
  task automatic t_mon;
    n_start = 0;
    cyc(40);
    chk("monitor runs", 8'h01, {7'h00, n_start >= 5});
    chk("monitor_on", 8'h01, {7'h00, mon});
    i_host.wr(CF, 8'h00);
    cyc(6);
    chk("monitor_on off", 8'h00, {7'h00, mon});
    n_start = 0;
    cyc(40);
    chk("monitor stopped", 8'h00, 8'(n_start));
  endtask
  task automatic t_timeout;
    int k;
    int r;
    i_host.wr(CF, 8'h08);
    xact = 1'b1;
    for (k = 1; k < 40 && rel !== 1'b1; k++) @(negedge mclk_i);
    chk("release timing", 8'h01, {7'h00, k >= 22 && k <= 24});
    if (k >= 40) begin
      tally_and_finish();
    end
    xact = 1'b0;
    cyc(1);
    // a fresh transaction with steady activity never counts as a stall
    {xact, act} = 2'b11;
    r = 0;
    repeat (40) begin
      @(negedge mclk_i);
      r += int'(rel === 1'b1);
    end
    chk("release with activity", 8'h00, 8'(r));
    {xact, act} = 2'b00;
    i_host.wr(CF, 8'h00);
    xact = 1'b1;
    r = 0;
    repeat (40) begin
      @(negedge mclk_i);
      r += int'(rel === 1'b1);
    end
    chk("release disabled", 8'h00, 8'(r));
    xact = 1'b0;
  endtask
  task automatic t_soft;
    i_host.wr(CF, 8'hc8);
    i_host.wr(LR, 8'h02);
    chk("soft_reset pulse", 8'h01, {7'h00, srst});
    cyc(1);
    chk("soft_reset end", 8'h00, {7'h00, srst});
    rdchk("config restored", CF, 8'h07);
    rdchk("reset bit clear", LR, 8'h00);
  endtask
  task automatic t_lock;
    logic [7:0] d;
    logic       ok;
    i_host.wr(CF, 8'h08);
    i_host.wr(LR, 8'h01);
    chk("lock pin", 8'h01, {7'h00, lock});
    rdchk("lock set", LR, 8'h01);
    i_host.wr(LR, 8'h02);
    i_host.wr(CF, 8'h00);
    rdchk("config frozen bit", CF, 8'h08);
    rdchk("lock held", LR, 8'h01);
    i_host.rd(8'hd5, d, ok);
    chk("unserved valid", 8'h00, {7'h00, ok});
    rst_n_i = 1'b0;
    cyc(16);
    rst_n_i = 1'b1;
    rdchk("lock after power cycle", LR, 8'h00);
    chk("lock pin after power cycle", 8'h00, {7'h00, lock});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst_n_i = 1'b1;
    t_por();
    t_phase();
    t_pins();
    i_host.wr(CF, 8'h01);
    t_mon();
    t_timeout();
    t_soft();
    t_lock();
    tally_and_finish();
  end
  // a hang is cut short and judged as a mismatch
  initial begin
    #200_000;
    bad_count++;
    $display("[ERR] run_time expected done seen hung");
    tally_and_finish();
  end
endmodule
